// file: common/tap_pkg.sv
// Shared constants and types for the master test access port.
// Assumes one external host driving the test clock, mode select and data in.
package tap_pkg;

  localparam int unsigned IR_W = 8;
  localparam int unsigned ID_W = 32;
  localparam int unsigned TMS_RESET_EDGES = 5;

  // Controller state codes are fixed by the port definition
  typedef enum logic [3:0] {
    ST_TEST_LOGIC_RESET = 4'hf,
    ST_RUN_TEST_IDLE    = 4'hc,
    ST_SELECT_DR        = 4'h7,
    ST_CAPTURE_DR       = 4'h6,
    ST_SHIFT_DR         = 4'h2,
    ST_EXIT1_DR         = 4'h1,
    ST_PAUSE_DR         = 4'h3,
    ST_EXIT2_DR         = 4'h0,
    ST_UPDATE_DR        = 4'h5,
    ST_SELECT_IR        = 4'h4,
    ST_CAPTURE_IR       = 4'he,
    ST_SHIFT_IR         = 4'ha,
    ST_EXIT1_IR         = 4'h9,
    ST_PAUSE_IR         = 4'hb,
    ST_EXIT2_IR         = 4'h8,
    ST_UPDATE_IR        = 4'hd
  } tap_state_t;

  localparam logic [IR_W-1:0] INSTR_BYPASS      = 8'hff;
  localparam logic [IR_W-1:0] INSTR_IDCODE      = 8'h02;
  localparam logic [IR_W-1:0] INSTR_RESERVED_A  = 8'h03;
  localparam logic [IR_W-1:0] INSTR_RESERVED_B  = 8'h04;
  localparam logic [IR_W-1:0] INSTR_LINK_SELECT = 8'h05;
  localparam logic [IR_W-1:0] INSTR_LOCKOUT     = 8'h08;

  // Value loaded into the instruction shift stage in capture-IR
  localparam logic [IR_W-1:0] IR_CAPTURE_VALUE  = 8'h01;

  localparam logic [2:0] TMS_CNT_ZERO = 3'h0;
  localparam logic [2:0] TMS_CNT_ONE  = 3'h1;
  localparam logic [2:0] TMS_CNT_MAX  = 3'h5;

  // Mode levels handed from the test clock domain to the system clock domain
  typedef struct packed {
    logic link_select;
    logic normal_mode;
    logic lockout_recovery;
  } tap_mode_t;

  localparam tap_mode_t MODE_RESET = '{link_select: 1'b0, normal_mode: 1'b1, lockout_recovery: 1'b0};

endpackage

// file: hdl/master_tap.sv
// Master test access port controller: state machine, instruction, bypass and id registers.
// Assumes tck_i, tms_i and tdi_i come from the external host; tms_i and tdi_i are timed to tck_i.
// Mode levels and data-update events are carried into the clk_i domain for the rest of the chip.

`timescale 1ns/1ps

module master_tap #(
  parameter logic [31:0] CHIP_ID = 32'h0a5c_3001  // Arbitrary identification value
) (
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              tck_i,
  input  wire logic              tms_i,
  input  wire logic              tdi_i,
  output logic                   tdo_o,
  output logic                   tdo_oe_o,
  output tap_pkg::tap_mode_t     mode_o,
  output logic                   dr_update_o
);

  // Test clock domain reset, brought over from the system reset
  logic                     tck_rst_meta_r;
  logic                     tck_rst_b_r;

  tap_pkg::tap_state_t      state_r;
  tap_pkg::tap_state_t      state_nxt;
  logic [2:0]               tms_cnt_r;
  logic [tap_pkg::IR_W-1:0] ir_shift_r;
  logic [tap_pkg::IR_W-1:0] ir_current_r;
  logic [tap_pkg::ID_W-1:0] id_shift_r;
  logic                     bypass_r;
  logic                     tdo_r;
  logic                     tdo_oe_r;
  logic                     dr_update_tgl_r;

  // Clock domain system side
  tap_pkg::tap_mode_t       mode_meta_r;
  tap_pkg::tap_mode_t       mode_r;
  logic                     upd_meta_r;
  logic                     upd_sync_r;
  logic                     upd_last_r;

  always_ff @(posedge tck_i) begin
    tck_rst_meta_r <= rst_b_i;
    tck_rst_b_r    <= tck_rst_meta_r;
  end

  // Decoding of the current state and instruction
  wire in_shift_dr  = (state_r == tap_pkg::ST_SHIFT_DR);
  wire in_shift_ir  = (state_r == tap_pkg::ST_SHIFT_IR);
  wire in_tlr       = (state_r == tap_pkg::ST_TEST_LOGIC_RESET);
  wire sel_idcode   = (ir_current_r == tap_pkg::INSTR_IDCODE);
  wire sel_link     = (ir_current_r == tap_pkg::INSTR_LINK_SELECT);
  wire sel_lockout  = (ir_current_r == tap_pkg::INSTR_LOCKOUT);
  wire sel_bypass   = !sel_idcode;
  wire dr_serial    = sel_idcode ? id_shift_r[0] : bypass_r;
  wire tdo_nxt      = in_shift_ir ? ir_shift_r[0] : dr_serial;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      tap_pkg::ST_TEST_LOGIC_RESET: state_nxt = tms_i ? tap_pkg::ST_TEST_LOGIC_RESET : tap_pkg::ST_RUN_TEST_IDLE;
      tap_pkg::ST_RUN_TEST_IDLE:    state_nxt = tms_i ? tap_pkg::ST_SELECT_DR : tap_pkg::ST_RUN_TEST_IDLE;
      tap_pkg::ST_SELECT_DR:        state_nxt = tms_i ? tap_pkg::ST_SELECT_IR : tap_pkg::ST_CAPTURE_DR;
      tap_pkg::ST_CAPTURE_DR:       state_nxt = tms_i ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
      tap_pkg::ST_SHIFT_DR:         state_nxt = tms_i ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
      tap_pkg::ST_EXIT1_DR:         state_nxt = tms_i ? tap_pkg::ST_UPDATE_DR : tap_pkg::ST_PAUSE_DR;
      tap_pkg::ST_PAUSE_DR:         state_nxt = tms_i ? tap_pkg::ST_EXIT2_DR : tap_pkg::ST_PAUSE_DR;
      tap_pkg::ST_EXIT2_DR:         state_nxt = tms_i ? tap_pkg::ST_UPDATE_DR : tap_pkg::ST_SHIFT_DR;
      tap_pkg::ST_UPDATE_DR:        state_nxt = tms_i ? tap_pkg::ST_SELECT_DR : tap_pkg::ST_RUN_TEST_IDLE;
      tap_pkg::ST_SELECT_IR:        state_nxt = tms_i ? tap_pkg::ST_TEST_LOGIC_RESET : tap_pkg::ST_CAPTURE_IR;
      tap_pkg::ST_CAPTURE_IR:       state_nxt = tms_i ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
      tap_pkg::ST_SHIFT_IR:         state_nxt = tms_i ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
      tap_pkg::ST_EXIT1_IR:         state_nxt = tms_i ? tap_pkg::ST_UPDATE_IR : tap_pkg::ST_PAUSE_IR;
      tap_pkg::ST_PAUSE_IR:         state_nxt = tms_i ? tap_pkg::ST_EXIT2_IR : tap_pkg::ST_PAUSE_IR;
      tap_pkg::ST_EXIT2_IR:         state_nxt = tms_i ? tap_pkg::ST_UPDATE_IR : tap_pkg::ST_SHIFT_IR;
      tap_pkg::ST_UPDATE_IR:        state_nxt = tms_i ? tap_pkg::ST_SELECT_DR : tap_pkg::ST_RUN_TEST_IDLE;
    endcase
  end

  always_ff @(posedge tck_i) begin
    if (!tck_rst_b_r) begin
      state_r <= tap_pkg::ST_TEST_LOGIC_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Run of TMS-high edges, kept for checking the reset walk
  always_ff @(posedge tck_i) begin
    if (!tck_rst_b_r || !tms_i) begin
      tms_cnt_r <= tap_pkg::TMS_CNT_ZERO;
    end else if (tms_cnt_r != tap_pkg::TMS_CNT_MAX) begin
      tms_cnt_r <= tms_cnt_r + tap_pkg::TMS_CNT_ONE;
    end
  end

  always_ff @(posedge tck_i) begin
    if (!tck_rst_b_r) begin
      ir_shift_r <= tap_pkg::IR_CAPTURE_VALUE;
    end else if (state_r == tap_pkg::ST_CAPTURE_IR) begin
      ir_shift_r <= tap_pkg::IR_CAPTURE_VALUE;
    end else if (in_shift_ir) begin
      ir_shift_r <= {tdi_i, ir_shift_r[tap_pkg::IR_W-1:1]};
    end
  end

  // identification register: captures the id in capture-DR, shifts TDI in shift-DR, else holds
  always_ff @(posedge tck_i) begin
    if (!tck_rst_b_r) begin
      id_shift_r <= CHIP_ID;
    end else if (sel_idcode && state_r == tap_pkg::ST_CAPTURE_DR) begin
      id_shift_r <= CHIP_ID;
    end else if (sel_idcode && in_shift_dr) begin
      id_shift_r <= {tdi_i, id_shift_r[tap_pkg::ID_W-1:1]};
    end
  end

  // bypass stage captures zero, then shifts TDI
  always_ff @(posedge tck_i) begin
    if (!tck_rst_b_r) begin
      bypass_r <= 1'b0;
    end else if (sel_bypass && state_r == tap_pkg::ST_CAPTURE_DR) begin
      bypass_r <= 1'b0;
    end else if (sel_bypass && in_shift_dr) begin
      bypass_r <= tdi_i;
    end
  end

  always_ff @(negedge tck_i) begin
    if (!tck_rst_b_r || in_tlr) begin
      ir_current_r <= tap_pkg::INSTR_IDCODE;
    end else if (state_r == tap_pkg::ST_UPDATE_IR) begin
      ir_current_r <= ir_shift_r;
    end
  end

  always_ff @(negedge tck_i) begin
    if (!tck_rst_b_r) begin
      tdo_r    <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else begin
      tdo_r    <= tdo_nxt;
      tdo_oe_r <= in_shift_dr || in_shift_ir;
    end
  end

  // output stage event on falling edge of update-DR
  always_ff @(negedge tck_i) begin
    if (!tck_rst_b_r) begin
      dr_update_tgl_r <= 1'b0;
    end else if (state_r == tap_pkg::ST_UPDATE_DR) begin
      dr_update_tgl_r <= !dr_update_tgl_r;
    end
  end

  assign tdo_o    = tdo_r;
  assign tdo_oe_o = tdo_oe_r;

  // Mode levels; in reset state the test logic stays out of the way
  tap_pkg::tap_mode_t mode_tck;
  tap_pkg::tap_mode_t mode_tck_r;
  assign mode_tck = '{link_select:      sel_link && !in_tlr,
                      normal_mode:      in_tlr || sel_idcode || sel_bypass && !sel_link && !sel_lockout,
                      lockout_recovery: sel_lockout && !in_tlr};

  // A decode of several changing state bits can glitch, so only a flop may cross
  // registered mode levels
  always_ff @(negedge tck_i) begin
    if (!tck_rst_b_r) begin
      mode_tck_r <= tap_pkg::MODE_RESET;
    end else begin
      mode_tck_r <= mode_tck;
    end
  end

  // Levels cross by two flops; bits change only at update-IR or on entering test-logic-reset, far apart on the system clock
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      mode_meta_r <= tap_pkg::MODE_RESET;
      mode_r      <= tap_pkg::MODE_RESET;
    end else begin
      mode_meta_r <= mode_tck_r;
      mode_r      <= mode_meta_r;
    end
  end

  // Update events cross as a toggle
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      upd_meta_r <= 1'b0;
      upd_sync_r <= 1'b0;
      upd_last_r <= 1'b0;
    end else begin
      upd_meta_r <= dr_update_tgl_r;
      upd_sync_r <= upd_meta_r;
      upd_last_r <= upd_sync_r;
    end
  end

  assign mode_o      = mode_r;
  assign dr_update_o = upd_sync_r ^ upd_last_r;

  // Checks in the test clock domain
  default clocking cb @(posedge tck_i); endclocking
  // System reset also covers the first edges, before the test side reset is defined
  default disable iff (!tck_rst_b_r || !rst_b_i);

  sequence s_load_link;
    (state_r == tap_pkg::ST_UPDATE_IR) && (ir_shift_r == tap_pkg::INSTR_LINK_SELECT) ##1 1'b1;
  endsequence

  sequence s_shift_bit;
    in_shift_dr && sel_bypass;
  endsequence

  a_five_tms_reset: assert property (tms_cnt_r == tap_pkg::TMS_CNT_MAX |-> in_tlr)
    else $error("Five TMS-high edges did not reach reset state");
  a_idle_hold: assert property (state_r == tap_pkg::ST_RUN_TEST_IDLE && !tms_i |=>
    state_r == tap_pkg::ST_RUN_TEST_IDLE)
    else $error("Idle state left with TMS low");
  a_select_ir_exit: assert property (state_r == tap_pkg::ST_SELECT_IR && tms_i |=> in_tlr)
    else $error("Select-IR with TMS high did not reset");
  a_reset_loads_id: assert property (in_tlr |=> ir_current_r == tap_pkg::INSTR_IDCODE)
    else $error("Reset state did not load id instruction");
  a_update_ir_latch: assert property (state_r == tap_pkg::ST_UPDATE_IR |=>
    ir_current_r == $past(ir_shift_r))
    else $error("Instruction not latched in update-IR");
  a_instr_hold: assert property (state_r != tap_pkg::ST_UPDATE_IR && !in_tlr |->
    ir_current_r == $past(ir_current_r))
    else $error("Current instruction changed outside update");
  a_tdo_enable: assert property (tdo_oe_o == (in_shift_dr || in_shift_ir))
    else $error("TDO enable does not match shift states");
  a_bypass_path: assert property (s_shift_bit |=> bypass_r == $past(tdi_i))
    else $error("Bypass stage did not take TDI");
  a_id_capture: assert property (sel_idcode && state_r == tap_pkg::ST_CAPTURE_DR |=>
    id_shift_r == CHIP_ID)
    else $error("Id register not captured");
  a_ir_shift: assert property (in_shift_ir |=>
    ir_shift_r == {$past(tdi_i), $past(ir_shift_r[tap_pkg::IR_W-1:1])})
    else $error("Instruction register did not shift");
  a_link_select: assert property (s_load_link |-> mode_tck_r.link_select)
    else $error("Link select instruction not applied");
  a_exit1_dr_pause: assert property (state_r == tap_pkg::ST_EXIT1_DR && !tms_i |=>
    state_r == tap_pkg::ST_PAUSE_DR)
    else $error("Exit1-DR with TMS low did not pause");
  a_tlr_hold: assert property (in_tlr && tms_i |=> in_tlr)
    else $error("Reset state left with TMS high");
  a_select_dr_next: assert property (state_r == tap_pkg::ST_SELECT_DR |=>
    state_r == ($past(tms_i) ? tap_pkg::ST_SELECT_IR : tap_pkg::ST_CAPTURE_DR))
    else $error("Select-DR went to a wrong state");
  a_select_dr_hold: assert property (state_r == tap_pkg::ST_SELECT_DR |=>
    id_shift_r == $past(id_shift_r) && bypass_r == $past(bypass_r))
    else $error("Data registers changed in select-DR");
  a_bypass_capture: assert property (sel_bypass && state_r == tap_pkg::ST_CAPTURE_DR |=> !bypass_r)
    else $error("Bypass stage not cleared in capture-DR");
  a_id_shift: assert property (sel_idcode && in_shift_dr |=>
    id_shift_r == {$past(tdi_i), $past(id_shift_r[tap_pkg::ID_W-1:1])})
    else $error("Id register did not shift");
  a_shift_dr_next: assert property (in_shift_dr |=>
    state_r == ($past(tms_i) ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR))
    else $error("Shift-DR went to a wrong state");
  a_tdo_id_bit: assert property (in_shift_dr && sel_idcode |-> tdo_o == id_shift_r[0])
    else $error("TDO does not show the id register bit");
  a_tdo_ir_bit: assert property (in_shift_ir |-> tdo_o == ir_shift_r[0])
    else $error("TDO does not show the instruction bit");
  a_exit1_dr_update: assert property (state_r == tap_pkg::ST_EXIT1_DR && tms_i |=>
    state_r == tap_pkg::ST_UPDATE_DR)
    else $error("Exit1-DR with TMS high did not update");
  a_pause_dr_hold: assert property (state_r == tap_pkg::ST_PAUSE_DR |=>
    id_shift_r == $past(id_shift_r) && bypass_r == $past(bypass_r))
    else $error("Data registers changed in pause-DR");
  a_pause_dr_next: assert property (state_r == tap_pkg::ST_PAUSE_DR |=>
    state_r == ($past(tms_i) ? tap_pkg::ST_EXIT2_DR : tap_pkg::ST_PAUSE_DR))
    else $error("Pause-DR went to a wrong state");
  a_exit2_dr_next: assert property (state_r == tap_pkg::ST_EXIT2_DR |=>
    state_r == ($past(tms_i) ? tap_pkg::ST_UPDATE_DR : tap_pkg::ST_SHIFT_DR))
    else $error("Exit2-DR went to a wrong state");
  a_update_dr_event: assert property (state_r == tap_pkg::ST_UPDATE_DR |->
    dr_update_tgl_r != $past(dr_update_tgl_r))
    else $error("Update-DR gave no update event");
  a_update_dr_next: assert property (state_r == tap_pkg::ST_UPDATE_DR |=>
    state_r == ($past(tms_i) ? tap_pkg::ST_SELECT_DR : tap_pkg::ST_RUN_TEST_IDLE))
    else $error("Update-DR went to a wrong state");
  a_capture_ir_load: assert property (state_r == tap_pkg::ST_CAPTURE_IR |=>
    ir_shift_r == tap_pkg::IR_CAPTURE_VALUE)
    else $error("Instruction capture value not loaded");
  a_capture_ir_next: assert property (state_r == tap_pkg::ST_CAPTURE_IR |=>
    state_r == ($past(tms_i) ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR))
    else $error("Capture-IR went to a wrong state");
  a_exit1_ir_next: assert property (state_r == tap_pkg::ST_EXIT1_IR |=>
    state_r == ($past(tms_i) ? tap_pkg::ST_UPDATE_IR : tap_pkg::ST_PAUSE_IR))
    else $error("Exit1-IR went to a wrong state");
  a_pause_ir_hold: assert property (state_r == tap_pkg::ST_PAUSE_IR |=>
    ir_shift_r == $past(ir_shift_r))
    else $error("Instruction shift stage changed in pause-IR");
  a_pause_ir_next: assert property (state_r == tap_pkg::ST_PAUSE_IR |=>
    state_r == ($past(tms_i) ? tap_pkg::ST_EXIT2_IR : tap_pkg::ST_PAUSE_IR))
    else $error("Pause-IR went to a wrong state");
  a_exit2_ir_next: assert property (state_r == tap_pkg::ST_EXIT2_IR |=>
    state_r == ($past(tms_i) ? tap_pkg::ST_UPDATE_IR : tap_pkg::ST_SHIFT_IR))
    else $error("Exit2-IR went to a wrong state");
  a_update_ir_next: assert property (state_r == tap_pkg::ST_UPDATE_IR |=>
    state_r == ($past(tms_i) ? tap_pkg::ST_SELECT_DR : tap_pkg::ST_RUN_TEST_IDLE))
    else $error("Update-IR went to a wrong state");

endmodule

// file: verif/jtag_host.sv
// External test host model: makes the test clock, mode select and data in, samples data out.
// Assumes the port updates data out on the falling edge and samples on the rising edge.
`timescale 1ns/1ps
module jtag_host (
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i
);
  logic last_r;
  logic oe_seen;
  int   oe_miss;
  wire  tdo_w;
  // Released line shows the inverse of its last bit, so a stale bit never matches
  assign tdo_w = tdo_oe_i ? tdo_i : ~last_r;
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
    last_r = 1'b0;
    oe_seen = 1'b0;
    oe_miss = 0;
  end
  task automatic step(input logic m, input logic d, output logic o);
    #1;
    tms_o = m;
    tdi_o = d;
    #15;
    o = tdo_w;
    oe_seen = tdo_oe_i;
    last_r = o;
    tck_o = 1'b1;
    #16;
    tck_o = 1'b0;
  endtask
  task automatic shift(input int n, input logic [39:0] d, output logic [39:0] o);
    logic b;
    o = '0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, d[i], b);
      o[i] = b;
      if (oe_seen !== 1'b1) oe_miss++;
    end
  endtask
endmodule

// file: verif/testbench.sv
// Self-checking bench for the master test access port.
// Assumes a host model on the test pins and a free-running system clock.
`timescale 1ns/1ps
module testbench;
  localparam logic [31:0] ID_VAL = 32'h5e1d_7a0b;  // Arbitrary identification value
  localparam logic [39:0] PAT    = 40'h96_c3a5_5a3c;
  typedef struct packed {
    logic [7:0]         instr;
    logic [5:0]         len;
    tap_pkg::tap_mode_t mode;
  } row_t;
  logic               clk_i;
  logic               rst_b_i;
  logic               tck;
  logic               tms;
  logic               tdi;
  logic               tdo;
  logic               tdo_oe;
  logic               dr_update;
  tap_pkg::tap_mode_t mode;
  logic               b;
  logic [39:0]        o1;
  logic [39:0]        o2;
  int                 mismatches = 0;
  int                 total_checks = 0;
  int                 upd_cnt = 0;
  int                 u0;
  row_t               rows [6] = '{'{8'hff, 6'h01, 3'h2}, '{8'h02, 6'h20, 3'h2}, '{8'h03, 6'h01, 3'h2},
                                   '{8'h04, 6'h01, 3'h2}, '{8'h05, 6'h01, 3'h4}, '{8'h08, 6'h01, 3'h1}};

  master_tap #(.CHIP_ID(ID_VAL)) uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .tdo_o(tdo), .tdo_oe_o(tdo_oe), .mode_o(mode), .dr_update_o(dr_update));
  jtag_host host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_i(tdo_oe));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (dr_update === 1'b1) upd_cnt++;

  function automatic logic [39:0] exp_scan(input int len, input logic [39:0] p);
    logic [63:0] e;
    e = ({24'h0, p} << len) | ((len == 32) ? {32'h0, ID_VAL} : 64'h0);
    return e[39:0];
  endfunction
  task automatic check(input string name, input logic [39:0] exp, input logic [39:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wait_mode(input tap_pkg::tap_mode_t exp);
    repeat (5) @(posedge clk_i);
    #2;
    check("mode", {37'h0, exp}, {37'h0, mode});
  endtask
  task automatic ir_load(input logic [7:0] ins);
    logic [39:0] o;
    u0 = upd_cnt;
    host.step(1'b1, 1'b0, b);
    host.step(1'b1, 1'b0, b);
    host.step(1'b0, 1'b0, b);
    host.step(1'b0, 1'b0, b);
    host.shift(8, {32'h0, ins}, o);
    host.step(1'b1, 1'b0, b);
    host.step(1'b0, 1'b0, b);
    repeat (6) @(posedge clk_i);
    check("ir capture", 40'h01, o);
    check("ir no update", 40'h0, 40'(upd_cnt - u0));
  endtask
  task automatic dr_scan(input int n, input logic [39:0] p, output logic [39:0] o);
    u0 = upd_cnt;
    host.step(1'b1, 1'b0, b);
    host.step(1'b0, 1'b0, b);
    host.step(1'b0, 1'b0, b);
    host.shift(n, p, o);
    host.step(1'b1, 1'b0, b);
    host.step(1'b0, 1'b0, b);
    repeat (6) @(posedge clk_i);
    check("update pulses", 40'h1, 40'(upd_cnt - u0));
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_i);
    mismatches++;
    $display("[FAIL] run length expected finish seen timeout");
    final_report();
  end

  initial begin
    rst_b_i = 1'b0;
    fork
      repeat (7) host.step(1'b1, 1'b0, b);
      begin
        repeat (8) @(posedge clk_i);
        #2;
        rst_b_i = 1'b1;
      end
    join
    repeat (3) host.step(1'b1, 1'b0, b);
    wait_mode(3'h2);
    check("idle enable", 40'h0, {39'h0, tdo_oe});
    repeat (3) host.step(1'b0, 1'b0, b);
    dr_scan(40, PAT, o1);
    check("id after reset", exp_scan(32, PAT), o1);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      ir_load(rows[i].instr);
      wait_mode(rows[i].mode);
      dr_scan(40, PAT, o1);
      check("dr path", exp_scan(int'(rows[i].len), PAT), o1);
      wait_mode(rows[i].mode);
      $display("row %0d done", i);
    end
    ir_load(8'h02);
    u0 = upd_cnt;
    host.step(1'b1, 1'b0, b);
    host.step(1'b0, 1'b0, b);
    host.step(1'b0, 1'b0, b);
    host.shift(10, PAT, o1);
    host.step(1'b0, 1'b0, b);
    host.step(1'b0, 1'b0, b);
    #2;
    check("pause enable", 40'h0, {39'h0, tdo_oe});
    host.step(1'b1, 1'b0, b);
    host.step(1'b0, 1'b0, b);
    host.shift(30, PAT >> 10, o2);
    host.step(1'b1, 1'b0, b);
    host.step(1'b0, 1'b0, b);
    repeat (6) @(posedge clk_i);
    check("paused dr", exp_scan(32, PAT), {o2[29:0], o1[9:0]});
    check("pause updates", 40'h1, 40'(upd_cnt - u0));
    $display("pause dr test done");
    host.step(1'b1, 1'b0, b);
    host.step(1'b1, 1'b0, b);
    host.step(1'b0, 1'b0, b);
    host.step(1'b0, 1'b0, b);
    host.shift(4, 40'h8, o1);
    host.step(1'b0, 1'b0, b);
    host.step(1'b0, 1'b0, b);
    host.step(1'b1, 1'b0, b);
    host.step(1'b0, 1'b0, b);
    host.shift(4, 40'h0, o2);
    host.step(1'b1, 1'b0, b);
    host.step(1'b0, 1'b0, b);
    check("ir split capture", 40'h01, {32'h0, o2[3:0], o1[3:0]});
    wait_mode(3'h1);
    $display("pause ir test done");
    host.step(1'b1, 1'b0, b);
    host.step(1'b0, 1'b0, b);
    host.step(1'b0, 1'b0, b);
    repeat (5) host.step(1'b1, 1'b0, b);
    wait_mode(3'h2);
    host.step(1'b0, 1'b0, b);
    $display("tms reset test done");
    ir_load(8'h05);
    wait_mode(3'h4);
    repeat (3) host.step(1'b1, 1'b0, b);
    wait_mode(3'h2);
    host.step(1'b0, 1'b0, b);
    dr_scan(40, PAT, o1);
    check("id after select-ir", exp_scan(32, PAT), o1);
    check("shift enable", 40'h0, 40'(host.oe_miss));
    $display("select-ir test done");
    final_report();
  end
endmodule
